// ---- hw/icd_ctrl.sv ----
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ps
module icd_ctrl
    import icd_pkg::*;
#(
    parameter int NCH          = ICD_CHANNELS,
    parameter int DIG_FIRST    = ICD_DIG_FIRST,
    parameter int WET_UNIT_CYC = ICD_WET_UNIT_CYC
) (
    input  wire logic              clk_sys_i,
    input  wire logic              srst_i,
    input  wire logic [ICD_AW-1:0] reg_addr_i,
    input  wire logic [ICD_DW-1:0] reg_wdata_i,
    input  wire logic              reg_wr_i,
    input  wire logic              reg_rd_i,
    output logic      [ICD_DW-1:0] reg_rdata_o,
    input  wire logic [NCH-1:0]    cmp_i,
    input  wire logic              sleep_i,
    output icd_drive_t             drive_o [NCH],
    output logic      [4:0]        rail_level_o
);

    ////////////////////////////////////////////////////////////////////////
    // functions

    function automatic logic [14:0] strength_ua(input logic [2:0] c);
        logic [14:0] r;
        r = ICD_UA_CODE0;
        unique case (c)
            3'h0: r = ICD_UA_CODE0;
            3'h1: r = ICD_UA_CODE1;
            3'h2: r = ICD_UA_CODE2;
            3'h3: r = ICD_UA_CODE3;
            3'h4: r = ICD_UA_CODE4;
            3'h5: r = ICD_UA_CODE5;
            3'h6: r = ICD_UA_CODE6;
            3'h7: r = ICD_UA_CODE7;
        endcase
        return r;
    endfunction

    function automatic logic [ICD_CW-1:0] wet_len(input logic [2:0] d);
        return ICD_CW'((int'(d) + 1) * WET_UNIT_CYC - 1);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // shared registers and bus

    icd_chan_cfg_t       cfg_q [NCH];
    logic [4:0]          lvl_q;
    logic [2:0]          dur_q;
    logic [ICD_DW-1:0]   rdata_q;
    logic [ICD_DW-1:0]   rdata_d;
    wire  [NCH-1:0]      active_q;
    logic                sleep_q;
    logic [NCH-1:0]      cmp_s1_q;
    logic [NCH-1:0]      cmp_s2_q;
    logic [NCH-1:0]      cmp_prev_q;

    wire                 wr_shared = reg_wr_i && (reg_addr_i == ICD_OFS_SHARED);
    wire                 wake_pulse = sleep_q && !sleep_i;
    wire [ICD_AW-1:0]    chan_idx = reg_addr_i - ICD_OFS_CHAN0;
    wire                 addr_is_chan = (reg_addr_i >= ICD_OFS_CHAN0) &&
                                        (chan_idx < ICD_AW'(NCH));
    wire [ICD_DW-1:0]    chan_rd = ICD_DW'(cfg_q[chan_idx[3:0]]);
    wire [ICD_DW-1:0]    shared_rd = ICD_DW'({dur_q, lvl_q});
    wire [ICD_DW-1:0]    status_rd = ICD_DW'(active_q);

    always_comb begin
        rdata_d = '0;
        if (reg_rd_i) begin
            if (addr_is_chan) begin
                rdata_d = chan_rd;
            end else if (reg_addr_i == ICD_OFS_SHARED) begin
                rdata_d = shared_rd;
            end else if (reg_addr_i == ICD_OFS_STATUS) begin
                rdata_d = status_rd;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            lvl_q   <= ICD_LVL_RST;
            dur_q   <= ICD_DUR_RST;
            rdata_q <= '0;
            sleep_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            sleep_q <= sleep_i;
            if (wr_shared) begin
                lvl_q <= reg_wdata_i[ICD_LVL_LSB +: 5];
                dur_q <= reg_wdata_i[ICD_DUR_LSB +: 3];
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            cmp_s1_q   <= '0;
            cmp_s2_q   <= '0;
            cmp_prev_q <= '0;
        end else begin
            cmp_s1_q   <= cmp_i;
            cmp_s2_q   <= cmp_s1_q;
            cmp_prev_q <= cmp_s2_q;
        end
    end

    assign reg_rdata_o = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // per-channel logic

    generate
        for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
            logic [ICD_CW-1:0] cnt_q;
            icd_drive_t        drv_q;
            icd_drive_t        drv_d;
            icd_rail_t         rail_eff;
            logic              act_q;

            assign active_q[ch] = act_q;

            wire wr_me  = reg_wr_i && addr_is_chan && (chan_idx == ICD_AW'(ch));
            wire fall   = cmp_prev_q[ch] && !cmp_s2_q[ch];
            wire rise   = !cmp_prev_q[ch] && cmp_s2_q[ch];
            wire edge_ok = !sleep_i && cfg_q[ch].wet_en &&
                           (((cfg_q[ch].dir == ICD_DIR_UP) && fall) ||
                            ((cfg_q[ch].dir == ICD_DIR_DOWN) && rise));
            wire wake_ok = wake_pulse && cfg_q[ch].wet_en;
            wire start  = (edge_ok || wake_ok) && !active_q[ch];
            wire done   = active_q[ch] && (cnt_q == '0);

            // rails other than the clamped one are invalid on digital inputs
            assign rail_eff = ((ch >= DIG_FIRST) || (cfg_q[ch].rail == ICD_RAIL_RSV)) ?
                              ICD_RAIL_CLAMP : cfg_q[ch].rail;

            always_comb begin
                drv_d            = '0;
                drv_d.on         = !sleep_i &&
                                   ((cfg_q[ch].dir == ICD_DIR_UP) ||
                                    (cfg_q[ch].dir == ICD_DIR_DOWN));
                drv_d.dir        = drv_d.on ? cfg_q[ch].dir : ICD_DIR_OFF;
                drv_d.rail       = rail_eff;
                drv_d.wetting    = active_q[ch];
                drv_d.wet_code   = cfg_q[ch].wet_code;
                drv_d.code       = cfg_q[ch].code;
                drv_d.nominal_ua = strength_ua(cfg_q[ch].code);
            end

            always_ff @(posedge clk_sys_i) begin
                if (srst_i) begin
                    cfg_q[ch]    <= icd_chan_cfg_t'(ICD_CHAN_RST);
                    cnt_q        <= '0;
                    act_q        <= 1'b0;
                    drv_q        <= '0;
                end else begin
                    drv_q <= drv_d;
                    if (wr_me) begin
                        cfg_q[ch] <= icd_chan_cfg_t'(reg_wdata_i[ICD_CHAN_BITS-1:0]);
                    end
                    if (sleep_i) begin
                        act_q        <= 1'b0;
                        cnt_q        <= '0;
                    end else if (start) begin
                        act_q        <= 1'b1;
                        cnt_q        <= wet_len(dur_q);
                    end else if (done) begin
                        act_q        <= 1'b0;
                    end else if (active_q[ch]) begin
                        cnt_q <= cnt_q - ICD_CW'(1);
                    end
                end
            end

            assign drive_o[ch] = drv_q;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // shared rail level output

    logic [4:0] lvl_out_q;

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            lvl_out_q <= ICD_LVL_RST;
        end else begin
            lvl_out_q <= lvl_q;
        end
    end

    assign rail_level_o = lvl_out_q;

endmodule

// ---- hw/icd_pkg.sv ----
// How it works
// - pull-up limited to clamped, five-volt or programmable rail
// - per-channel strength and rail, shared rail level
// - shared 3-bit duration, per-channel 2-bit wetting current
// - wetting disabled on every channel after reset
// - pull-up: falling comparator edge starts wetting
// - pull-down: rising comparator edge starts wetting
// - duration elapsed restores normal strength code
// - sleep to normal starts wetting on enabled channels
// - strength code selects nominal current per table
// - sources off asleep, configuration kept
// - digital channels always use clamped rail
package icd_pkg;

    localparam int ICD_CHANNELS   = 15;
    localparam int ICD_DIG_FIRST  = 12;
    localparam int ICD_AW         = 5;
    localparam int ICD_DW         = 16;
    localparam int ICD_CW         = 20;

    localparam logic [ICD_AW-1:0] ICD_OFS_CHAN0  = 5'h00;
    localparam logic [ICD_AW-1:0] ICD_OFS_SHARED = 5'h10;
    localparam logic [ICD_AW-1:0] ICD_OFS_STATUS = 5'h11;

    // channel register: [9:8] rail, [7:6] direction, [5] wetting enable,
    // [4] wetting hi, [3] wetting lo, [2:0] normal code
    localparam int ICD_CHAN_BITS  = 10;
    // shared register: [7:5] duration, [4:0] programmable rail level
    localparam int ICD_LVL_LSB    = 0;
    localparam int ICD_DUR_LSB    = 5;

    localparam logic [ICD_CHAN_BITS-1:0] ICD_CHAN_RST   = 10'h000;
    localparam logic [4:0]               ICD_LVL_RST    = 5'h00;
    localparam logic [2:0]               ICD_DUR_RST    = 3'h0;

    localparam int ICD_CLK_MHZ     = 25;
    localparam int ICD_WET_UNIT_US = 1000;
    localparam int ICD_WET_UNIT_CYC = ICD_WET_UNIT_US * ICD_CLK_MHZ;

    localparam logic [14:0] ICD_UA_CODE0 = 15'h0258;
    localparam logic [14:0] ICD_UA_CODE1 = 15'h0014;
    localparam logic [14:0] ICD_UA_CODE2 = 15'h0064;
    localparam logic [14:0] ICD_UA_CODE3 = 15'h01F4;
    localparam logic [14:0] ICD_UA_CODE4 = 15'h03E8;
    localparam logic [14:0] ICD_UA_CODE5 = 15'h1388;
    localparam logic [14:0] ICD_UA_CODE6 = 15'h2710;
    localparam logic [14:0] ICD_UA_CODE7 = 15'h4E20;

    typedef enum logic [1:0] {
        ICD_DIR_OFF  = 2'b00,
        ICD_DIR_UP   = 2'b01,
        ICD_DIR_DOWN = 2'b10,
        ICD_DIR_RSV  = 2'b11
    } icd_dir_t;

    typedef enum logic [1:0] {
        ICD_RAIL_CLAMP = 2'b00,
        ICD_RAIL_FIVE  = 2'b01,
        ICD_RAIL_PROG  = 2'b10,
        ICD_RAIL_RSV   = 2'b11
    } icd_rail_t;

    typedef struct packed {
        icd_rail_t  rail;
        icd_dir_t   dir;
        logic       wet_en;
        logic [1:0] wet_code;
        logic [2:0] code;
    } icd_chan_cfg_t;

    typedef struct packed {
        logic        on;
        icd_dir_t    dir;
        icd_rail_t   rail;
        logic        wetting;
        logic [1:0]  wet_code;
        logic [2:0]  code;
        logic [14:0] nominal_ua;
    } icd_drive_t;

endpackage

// ---- test/icd_checker.sv ----
`timescale 1ns/1ps
module icd_checker
    import icd_pkg::*;
#(
    parameter int NCH          = ICD_CHANNELS,
    parameter int DIG_FIRST    = ICD_DIG_FIRST,
    parameter int WET_UNIT_CYC = ICD_WET_UNIT_CYC
) (
    input wire logic              clk_sys_i,
    input wire logic              srst_i,
    input wire logic [ICD_AW-1:0] reg_addr_i,
    input wire logic [ICD_DW-1:0] reg_wdata_i,
    input wire logic              reg_wr_i,
    input wire logic              reg_rd_i,
    input wire logic [ICD_DW-1:0] reg_rdata_o,
    input wire logic [NCH-1:0]    cmp_i,
    input wire logic              sleep_i,
    input wire icd_drive_t        drive_o [NCH],
    input wire logic [4:0]        rail_level_o
);
    localparam logic [14:0] UA [8] = '{15'h0258, 15'h0014, 15'h0064, 15'h01F4, 15'h03E8, 15'h1388, 15'h2710, 15'h4E20};
    icd_chan_cfg_t cfg_q;
    logic [7:0]    shr_q;
    int            cnt_q;
    // shadow of channel 0 and shared settings, wetting length
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            cfg_q <= '0;
            shr_q <= '0;
            cnt_q <= 0;
        end else begin
            if (reg_wr_i && reg_addr_i == 5'h00) cfg_q <= reg_wdata_i[9:0];
            if (reg_wr_i && reg_addr_i == 5'h10) shr_q <= reg_wdata_i[7:0];
            cnt_q <= drive_o[0].wetting ? cnt_q + 1 : 0;
        end
    end
    ////////////////////////////////////////
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    rdata_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == '0) else $error("read data not idle");
    level_copy_a: assert property ($stable(shr_q) |-> rail_level_o == shr_q[4:0]) else $error("rail level");
    rail_sel_a: assert property ($stable(cfg_q) && drive_o[0].on && cfg_q.rail != ICD_RAIL_RSV
        |-> drive_o[0].rail == cfg_q.rail) else $error("rail select");
    dig_rail_a: assert property (drive_o[NCH-1].rail == ICD_RAIL_CLAMP) else $error("digital rail");
    nom_map_a: assert property (drive_o[0].on |-> drive_o[0].nominal_ua == UA[drive_o[0].code]) else $error("nominal");
    wet_off_a: assert property (!cfg_q.wet_en |-> !drive_o[0].wetting) else $error("wetting while disabled");
    fall_start_a: assert property ($fell(cmp_i[0]) && cfg_q.wet_en && cfg_q.dir == ICD_DIR_UP
        && !drive_o[0].wetting && !sleep_i |-> ##[1:5] drive_o[0].wetting) else $error("no start on fall");
    rise_start_a: assert property ($rose(cmp_i[0]) && cfg_q.wet_en && cfg_q.dir == ICD_DIR_DOWN
        && !drive_o[0].wetting && !sleep_i |-> ##[1:5] drive_o[0].wetting) else $error("no start on rise");
    wet_len_a: assert property ($fell(drive_o[0].wetting) && !sleep_i && !$past(sleep_i)
        |-> cnt_q == (shr_q[7:5] + 1) * WET_UNIT_CYC) else $error("wetting length");
    wake_start_a: assert property ($fell(sleep_i) && cfg_q.wet_en && cfg_q.dir == ICD_DIR_UP
        |-> ##[1:3] drive_o[0].wetting) else $error("no wetting on wake");
    sleep_off_a: assert property (sleep_i |=> !drive_o[0].on) else $error("source on while asleep");
    cover property (drive_o[0].wetting);
    cover property ($fell(sleep_i));
    cover property (reg_rd_i ##1 reg_rdata_o != '0);
endmodule
bind icd_ctrl icd_checker #(.NCH(NCH), .DIG_FIRST(DIG_FIRST), .WET_UNIT_CYC(WET_UNIT_CYC)) icd_checker_inst (
    .clk_sys_i, .srst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .cmp_i, .sleep_i, .drive_o, .rail_level_o);

// ---- test/icd_host.sv ----
`timescale 1ns/1ps
module icd_host
    import icd_pkg::*;
(
    input  wire logic              clk_i,
    output logic      [ICD_AW-1:0] addr_o,
    output logic      [ICD_DW-1:0] wdata_o,
    output logic                   wr_o,
    output logic                   rd_o
);
    logic [ICD_DW-1:0] exp_q [$];
    initial begin
        addr_o  = '0;
        wdata_o = '0;
        wr_o    = 1'h0;
        rd_o    = 1'h0;
    end
    // released bus shows inverted values
    task automatic wr(input logic [ICD_AW-1:0] a, input logic [ICD_DW-1:0] d);
        @(posedge clk_i);
        addr_o  <= a;
        wdata_o <= d;
        wr_o    <= 1'h1;
        @(posedge clk_i);
        wr_o    <= 1'h0;
        addr_o  <= ~a;
        wdata_o <= ~d;
    endtask
    task automatic rd(input logic [ICD_AW-1:0] a, input logic [ICD_DW-1:0] e);
        @(posedge clk_i);
        exp_q.push_back(e);
        addr_o <= a;
        rd_o   <= 1'h1;
        @(posedge clk_i);
        rd_o   <= 1'h0;
        addr_o <= ~a;
    endtask
endmodule

// ---- test/icd_ctrl_tb.sv ----
`timescale 1ns/1ps
module icd_ctrl_tb;
    import icd_pkg::*;
    logic              clk_sys_i = 1'h0;
    logic              srst_i    = 1'h1;
    logic [ICD_AW-1:0] reg_addr_i;
    logic [ICD_DW-1:0] reg_wdata_i;
    logic              reg_wr_i;
    logic              reg_rd_i;
    logic [ICD_DW-1:0] reg_rdata_o;
    logic [14:0]       cmp_i     = 15'h7FFF;
    logic              sleep_i   = 1'h0;
    icd_drive_t        drive_o [ICD_CHANNELS];
    logic [4:0]        rail_level_o;
    logic              rd_seen   = 1'h0;
    int                bad_count = 0;
    int                n_compared = 0;
    logic [2:0]        dur;
    logic [4:0]        lvl;
    logic [9:0]        c;
    always #20 clk_sys_i = ~clk_sys_i;
    icd_ctrl #(.WET_UNIT_CYC(4)) icd_ctrl_inst (.clk_sys_i, .srst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
        .reg_rd_i, .reg_rdata_o, .cmp_i, .sleep_i, .drive_o, .rail_level_o);
    icd_host icd_host_inst (.clk_i(clk_sys_i), .addr_o(reg_addr_i), .wdata_o(reg_wdata_i), .wr_o(reg_wr_i),
        .rd_o(reg_rd_i));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("ERROR %0t got %h expected %h", $time, got, exp);
            bad_count++;
        end
    endtask
    task automatic wait_wet(input logic v);
        for (int n = 0; n < 200 && drive_o[0].wetting !== v; n++) @(posedge clk_sys_i);
        chk(16'(drive_o[0].wetting), 16'(v));
    endtask
    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////
    always @(posedge clk_sys_i) begin
        if (rd_seen) chk(reg_rdata_o, icd_host_inst.exp_q.pop_front());
        rd_seen = reg_rd_i;
    end
    initial begin
        repeat (5000) @(posedge clk_sys_i);
        $display("ERROR %0t timeout", $time);
        bad_count++;
        complete_run();
    end
    initial begin
        void'($urandom(93732));
        repeat (12) @(posedge clk_sys_i);
        srst_i <= 1'h0;
        cmp_i  <= {14'($urandom), 1'h1};
        dur = 3'($urandom_range(7, 4));
        lvl = 5'($urandom_range(31));
        icd_host_inst.wr(5'h10, {8'h00, dur, lvl});
        icd_host_inst.wr(5'h0E, 16'h0240);
        for (int i = 0; i < 8; i++) begin
            c = {2'(i % 3), 2'h1, 1'h0, 2'($urandom_range(3)), 3'(i)};
            icd_host_inst.wr(5'h00, {6'h00, c});
            icd_host_inst.rd(5'h00, {6'h00, c});
        end
        icd_host_inst.rd(5'h10, {8'h00, dur, lvl});
        icd_host_inst.rd(5'h1F, 16'h0000);
        icd_host_inst.wr(5'h11, 16'hFFFF);
        icd_host_inst.rd(5'h11, 16'h0000);
        cmp_i[0] <= 1'h0;
        repeat (8) @(posedge clk_sys_i);
        icd_host_inst.rd(5'h11, 16'h0000);
        cmp_i[0] <= 1'h1;
        icd_host_inst.wr(5'h00, 16'h007F);
        repeat (8) @(posedge clk_sys_i);
        cmp_i[0] <= 1'h0;
        repeat (4) @(posedge clk_sys_i);
        cmp_i[0] <= 1'h1;
        repeat (4) @(posedge clk_sys_i);
        cmp_i[0] <= 1'h0;
        icd_host_inst.rd(5'h11, 16'h0001);
        wait_wet(1'h0);
        icd_host_inst.wr(5'h00, 16'h00BF);
        repeat (8) @(posedge clk_sys_i);
        cmp_i[0] <= 1'h1;
        wait_wet(1'h1);
        wait_wet(1'h0);
        icd_host_inst.wr(5'h00, 16'h007F);
        repeat (8) @(posedge clk_sys_i);
        sleep_i <= 1'h1;
        repeat (10) @(posedge clk_sys_i);
        chk(16'(drive_o[0].on), 16'h0000);
        icd_host_inst.rd(5'h00, 16'h007F);
        sleep_i <= 1'h0;
        wait_wet(1'h1);
        wait_wet(1'h0);
        repeat (4) @(posedge clk_sys_i);
        complete_run();
    end
endmodule
